//--- cpw_pkg.sv
// Purpose: constants and types shared by the capture/compare/PWM unit
// Assumes: 8-bit register port, one instruction clock
// Notes: offsets are byte addresses on the register port
//
// Overview of operation
// - One 16-bit word serves as capture, compare or PWM duty word by mode.
// - The 16-bit word is split into low and high 8-bit byte registers.
// - Software reads and writes low byte, high byte and unit control.
// - Capture and compare use the 16-bit timer; PWM uses the period timer.
// - Control bits 5:4 are the duty value's two low bits; unused otherwise.
// - Mode 0100 falling, 0101 rising, 0110 every 4th, 0111 every 16th rise.
// - Compare 1000 drives pin high, 1001 low on match; both set event flag.
// - Compare 1010 sets only the event flag on match, pin untouched.
// - Special event compare resets the 16-bit timer and starts a conversion.
// - Direction bit 2 low drives the pin, high tristates it; all reset high.
// - A capture copies the full 16-bit timer count into the word.
// - Each capture sets the unit event flag.
// - A new capture overwrites the word even if unread.
// - Edge prescaler clears when unit off or not capturing, and at reset.
// - Clearing unit control forces the output latch low.
// - Special event timer reset must not set the timer overflow flag.

package cpw_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFF_DATA = 8'h07;
  localparam logic [7:0] OFF_FLAG = 8'h0C;
  localparam logic [7:0] OFF_LOW = 8'h15;
  localparam logic [7:0] OFF_HIGH = 8'h16;
  localparam logic [7:0] OFF_CTRL = 8'h17;
  localparam logic [7:0] OFF_DIR = 8'h87;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DIR_RESET = 8'hFF;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK = 8'h3F;
  localparam logic [7:0] DATA_MASK = 8'h05;
  localparam logic [15:0] WORD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MODE_MSB = 3;
  localparam int DUTY_MSB = 5;
  localparam int DUTY_LSB = 4;
  localparam int FLAG_BIT = 2;
  localparam int PIN_BIT = 2;
  localparam int TCLK_BIT = 0;

  // ----------------------------------------------------------------
  // mode field codes
  // ----------------------------------------------------------------
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_R4 = 4'h6;
  localparam logic [3:0] MODE_CAP_R16 = 4'h7;
  localparam logic [3:0] MODE_CMP_SET = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR = 4'h9;
  localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
  localparam logic [3:0] MODE_CMP_SPEC = 4'hB;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;
  localparam logic [1:0] MODE_CAP_TOP = 2'h1;
  localparam logic [1:0] MODE_CMP_TOP = 2'h2;

  // prescaler terminal counts for every 4th and every 16th edge
  localparam logic [3:0] PS_LAST_4 = 4'h3;
  localparam logic [3:0] PS_LAST_16 = 4'hF;
  localparam logic [3:0] PS_ZERO = 4'h0;

  typedef enum logic [3:0] {
    CLS_OFF = 4'b0001,
    CLS_CAP = 4'b0010,
    CLS_CMP = 4'b0100,
    CLS_PWM = 4'b1000
  } cpw_cls_t;

endpackage : cpw_pkg

//--- cpw_edge_if.sv
// Purpose: carries synchronised pin edge pulses between unit modules
// Assumes: single clock domain
// Notes: pulses are one clock long

`timescale 1ns/10ps
`default_nettype none

interface cpw_edge_if;
  logic rise;
  logic fall;
  modport src (output rise, output fall);
  modport dst (input rise, input fall);
endinterface : cpw_edge_if

`default_nettype wire

//--- cpw_pin_sync.sv
// Purpose: synchronise the unit pin and detect its edges
// Assumes: pin is asynchronous to clock
// Notes: edge pulses lag the pin by about two clocks

`timescale 1ns/10ps
`default_nettype none

module cpw_pin_sync (
  input wire logic clock,
  input wire logic rst,
  input wire logic pin_in,
  cpw_edge_if.src ev
);
  logic meta;
  logic sync;
  logic last;

  // ----------------------------------------------------------------
  // two-stage synchroniser, then a history stage for edges
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else begin
      meta <= pin_in;
      sync <= meta;
      last <= sync;
    end
  end

  // one pulse per settled edge
  assign ev.rise = sync & ~last;
  assign ev.fall = ~sync & last;

  rise_once_a: assert property (@(posedge clock) disable iff (rst)
    ev.rise |=> !ev.rise) else $error("rise pulse longer than one clock");

endmodule : cpw_pin_sync

`default_nettype wire

//--- cpw_presc.sv
// Purpose: capture edge selection and prescaling
// Assumes: edge pulses already synchronised
// Notes: switching between prescaled modes keeps the count

`timescale 1ns/10ps
`default_nettype none

module cpw_presc
  import cpw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [3:0] mode,
  cpw_edge_if.dst ev,
  output logic capture_evt
);
  logic [3:0] count;
  logic is_cap;

  assign is_cap = (mode[MODE_MSB:2] == MODE_CAP_TOP);

  always_comb begin
    capture_evt = 1'b0;
    unique case (mode)
      MODE_CAP_FALL: capture_evt = ev.fall;
      MODE_CAP_RISE: capture_evt = ev.rise;
      MODE_CAP_R4: capture_evt = ev.rise && (count == PS_LAST_4);
      MODE_CAP_R16: capture_evt = ev.rise && (count == PS_LAST_16);
      default: capture_evt = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // rising edge counter
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst || !is_cap) begin
      count <= PS_ZERO;
    end else if (ev.rise) begin
      if (capture_evt) begin
        count <= PS_ZERO;
      end else begin
        count <= count + 4'h1;
      end
    end
  end

  presc_clear_a: assert property (@(posedge clock) disable iff (rst)
    !is_cap |=> count == PS_ZERO) else $error("prescaler not cleared");

endmodule : cpw_presc

`default_nettype wire

//--- cpw_unit.sv
// Purpose: capture/compare/PWM unit with its registers and pin control
// Assumes: timer counts arrive on the same clock; pin is asynchronous
// Notes: register port answers reads one clock after the strobe
//
// The plain strobed port was left to the implementer.

`timescale 1ns/10ps
`default_nettype none

module cpw_unit
  import cpw_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rd_data,
  input wire logic [15:0] timer_count,
  output logic timer_reset,
  output logic adc_start,
  input wire logic [9:0] pwm_base,
  input wire logic pwm_restart,
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic timer_clock_pin_out,
  output logic timer_clock_pin_oe_n,
  output logic unit_event_flag
);
  logic [7:0] unit_control;
  logic [7:0] pin_direction_control;
  logic [7:0] unit_pin_data_register;
  logic [15:0] match_capture_word;
  logic [9:0] duty_latch;
  logic out_latch;
  logic match_q;
  logic cmp_match;
  logic cmp_hit;
  logic capture_evt;
  logic cap_take;
  logic flag_clear;
  logic [3:0] mode;
  logic [9:0] duty_req;
  logic [7:0] next_rd;
  cpw_cls_t cls;

  cpw_edge_if edges ();

  cpw_pin_sync u_sync (
    .clock(clock),
    .rst(rst),
    .pin_in(pin_in),
    .ev(edges.src)
  );

  cpw_presc u_presc (
    .clock(clock),
    .rst(rst),
    .mode(mode),
    .ev(edges.dst),
    .capture_evt(capture_evt)
  );

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  assign mode = unit_control[MODE_MSB:0];
  assign duty_req = {match_capture_word[7:0], unit_control[DUTY_MSB:DUTY_LSB]};

  always_comb begin
    if (mode[MODE_MSB:2] == MODE_PWM_TOP) begin
      cls = CLS_PWM;
    end else if (mode[MODE_MSB:2] == MODE_CMP_TOP) begin
      cls = CLS_CMP;
    end else if (mode[MODE_MSB:2] == MODE_CAP_TOP) begin
      cls = CLS_CAP;
    end else begin
      cls = CLS_OFF;
    end
  end

  // compare fires once per arrival at the match value
  assign cmp_match = (cls == CLS_CMP) && (timer_count == match_capture_word);
  assign cmp_hit = cmp_match && !match_q;
  assign cap_take = (cls == CLS_CAP) && capture_evt;
  assign flag_clear = wr_strobe && (addr == OFF_FLAG) && !wr_data[FLAG_BIT];

  always_ff @(posedge clock) begin
    if (rst) begin
      match_q <= 1'b0;
    end else begin
      match_q <= cmp_match;
    end
  end

  // ----------------------------------------------------------------
  // control, direction and data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      unit_control <= CTRL_RESET;
    end else if (wr_strobe && addr == OFF_CTRL) begin
      unit_control <= wr_data & CTRL_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pin_direction_control <= DIR_RESET;
    end else if (wr_strobe && addr == OFF_DIR) begin
      pin_direction_control <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      unit_pin_data_register <= DATA_RESET;
    end else if (wr_strobe && addr == OFF_DATA) begin
      unit_pin_data_register <= wr_data & DATA_MASK;
    end
  end

  // ----------------------------------------------------------------
  // match/capture word
  // ----------------------------------------------------------------
  // hardware updates win over a software write in the same cycle
  always_ff @(posedge clock) begin
    if (rst) begin
      match_capture_word <= WORD_RESET;
    end else if (cap_take) begin
      match_capture_word <= timer_count;
    end else begin
      if (wr_strobe && addr == OFF_LOW) begin
        match_capture_word[7:0] <= wr_data;
      end
      if (cls == CLS_PWM && pwm_restart) begin
        match_capture_word[15:8] <= match_capture_word[7:0];
      end else if (wr_strobe && addr == OFF_HIGH) begin
        match_capture_word[15:8] <= wr_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // event flag
  // ----------------------------------------------------------------
  // a new event in the clearing cycle keeps the flag set
  always_ff @(posedge clock) begin
    if (rst) begin
      unit_event_flag <= 1'b0;
    end else if (cap_take || cmp_hit) begin
      unit_event_flag <= 1'b1;
    end else if (flag_clear) begin
      unit_event_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // compare / PWM output latch
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      out_latch <= 1'b0;
      duty_latch <= 10'h000;
    end else if (wr_strobe && addr == OFF_CTRL && wr_data == CTRL_RESET) begin
      out_latch <= 1'b0;
    end else if (cls == CLS_OFF) begin
      out_latch <= 1'b0;
    end else if (cls == CLS_PWM) begin
      if (pwm_restart) begin
        duty_latch <= duty_req;
        out_latch <= (duty_req != 10'h000);
      end else if (pwm_base == duty_latch) begin
        out_latch <= 1'b0;
      end
    end else if (cmp_hit && mode == MODE_CMP_SET) begin
      out_latch <= 1'b1;
    end else if (cmp_hit && mode == MODE_CMP_CLR) begin
      out_latch <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // special event trigger
  // ----------------------------------------------------------------
  // the timer treats this reset as a reload: no overflow flag follows
  always_ff @(posedge clock) begin
    if (rst) begin
      timer_reset <= 1'b0;
      adc_start <= 1'b0;
    end else begin
      timer_reset <= cmp_hit && (mode == MODE_CMP_SPEC);
      adc_start <= cmp_hit && (mode == MODE_CMP_SPEC);
    end
  end

  // ----------------------------------------------------------------
  // pins
  // ----------------------------------------------------------------
  // a driven pin in capture mode loops its own data back as edges
  always_comb begin
    if (cls == CLS_CMP || cls == CLS_PWM) begin
      pin_out = out_latch;
    end else begin
      pin_out = unit_pin_data_register[PIN_BIT];
    end
  end
  assign pin_oe_n = pin_direction_control[PIN_BIT];
  assign timer_clock_pin_out = unit_pin_data_register[TCLK_BIT];
  assign timer_clock_pin_oe_n = pin_direction_control[TCLK_BIT];

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  always_comb begin
    next_rd = 8'h00;
    unique case (addr)
      OFF_CTRL: next_rd = unit_control;
      OFF_DIR: next_rd = pin_direction_control;
      OFF_DATA: next_rd = unit_pin_data_register;
      OFF_LOW: next_rd = match_capture_word[7:0];
      OFF_HIGH: next_rd = match_capture_word[15:8];
      OFF_FLAG: next_rd = {5'h00, unit_event_flag, 2'h0};
      default: next_rd = 8'h00;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (rd_strobe) begin
      rd_data <= next_rd;
    end else begin
      rd_data <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  cap_copy_a: assert property (cap_take |=> match_capture_word == $past(timer_count))
    else $error("capture did not copy the timer count");
  cap_flag_a: assert property (cap_take |=> unit_event_flag)
    else $error("capture did not set the event flag");
  flag_hold_a: assert property (unit_event_flag && !flag_clear |=> unit_event_flag)
    else $error("event flag dropped without software clear");
  cmp_high_a: assert property (cmp_hit && mode == MODE_CMP_SET |=> pin_out || cls != CLS_CMP)
    else $error("compare set did not drive the pin high");
  cmp_low_a: assert property (cmp_hit && mode == MODE_CMP_CLR |=> !out_latch && unit_event_flag)
    else $error("compare clear did not drive the latch low");
  soft_keep_a: assert property (cmp_hit && mode == MODE_CMP_SOFT |=> $stable(out_latch))
    else $error("software compare changed the pin latch");
  spec_trig_a: assert property (cmp_hit && mode == MODE_CMP_SPEC
    |=> timer_reset && adc_start ##1 !timer_reset)
    else $error("special event trigger missing or too long");
  off_low_a: assert property (wr_strobe && addr == OFF_CTRL && wr_data == CTRL_RESET
    |=> !out_latch)
    else $error("clearing control left the output latch high");
  dir_drive_a: assert property (wr_strobe && addr == OFF_DIR && !wr_data[PIN_BIT]
    |=> !pin_oe_n)
    else $error("direction write did not enable the pin driver");

  // flag, off state, PWM reload, register port and special event pairing
  cmp_flag_a: assert property (cmp_hit |=> unit_event_flag)
    else $error("compare match did not set the event flag");
  clr_flag_a: assert property (flag_clear && !cap_take && !cmp_hit
    |=> !unit_event_flag)
    else $error("software clear left the event flag set");
  off_latch_a: assert property (cls == CLS_OFF |=> !out_latch)
    else $error("unit off left the output latch high");
  duty_load_a: assert property (cls == CLS_PWM && pwm_restart && !wr_strobe
    |=> duty_latch == $past(duty_req))
    else $error("period restart did not load the duty value");
  duty_copy_a: assert property (cls == CLS_PWM && pwm_restart
    |=> match_capture_word[15:8] == $past(match_capture_word[7:0]))
    else $error("period restart did not copy the duty byte");
  low_write_a: assert property (wr_strobe && addr == OFF_LOW && !cap_take
    |=> match_capture_word[7:0] == $past(wr_data))
    else $error("low byte write did not land");
  rd_ctrl_a: assert property (rd_strobe && addr == OFF_CTRL
    |=> rd_data == $past(unit_control))
    else $error("control read returned the wrong value");
  rd_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00)
    else $error("read data did not return to zero");
  spec_pair_a: assert property (timer_reset |-> adc_start)
    else $error("timer reset without conversion start");

  cap_seen_c: cover property (cap_take ##1 unit_event_flag);
  cmp_seen_c: cover property (cmp_hit && mode == MODE_CMP_SET);
  spec_seen_c: cover property (timer_reset && adc_start);
  pwm_seen_c: cover property (cls == CLS_PWM && pwm_restart && out_latch == 1'b0);
  flag_clr_c: cover property (flag_clear && unit_event_flag);

endmodule : cpw_unit

`default_nettype wire

//--- cpw_pin_model.sv
// Purpose: signal source and load on the unit pin
// Assumes: one clock; no pull resistor on the pin
// Notes: an undriven pin shows the inverse of its last level

`timescale 1ns/10ps
`default_nettype none

module cpw_pin_model (
  input wire logic clock,
  input wire logic src_en,
  input wire logic src_val,
  input wire logic pin_out,
  input wire logic pin_oe_n,
  output logic pin_level
);
  logic last = 1'b0;

  // ----------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------
  always_comb begin
    if (!pin_oe_n) begin
      pin_level = pin_out;
    end else if (src_en) begin
      pin_level = src_val;
    end else begin
      pin_level = ~last;
    end
  end

  // a released pin settles at the inverse of its last driven level
  always @(posedge clock) begin
    if (!pin_oe_n || src_en) begin
      last <= pin_level;
    end
  end
endmodule : cpw_pin_model

`default_nettype wire

//--- cpw_unit_tb_top.sv
// Purpose: self-checking bench for the capture/compare/PWM unit
// Assumes: 10 MHz clock, synchronous active-high reset
// Notes: bench owns the 16-bit timer and the period time base

`timescale 1ns/10ps
`default_nettype none

module cpw_unit_tb_top
  import cpw_pkg::*;
;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wr_data = 8'h00;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [7:0] rd_data;
  logic [15:0] tmr = 16'h0000;
  logic tmr_run = 1'b1;
  logic tmr_load = 1'b0;
  logic [15:0] tmr_set = 16'h0000;
  logic [9:0] pwm_base = 10'h000;
  logic pwm_restart = 1'b0;
  logic src_en = 1'b0;
  logic src_val = 1'b0;
  logic timer_reset, adc_start, pin_out, pin_oe_n, tck_out, tck_oe_n, flag, pin_level;
  int fail_count = 0;
  int cmp_count = 0;

  initial begin
    forever #50 clock = ~clock;
  end

  // ----------------------------------------------------------------
  // 16-bit timer and pin partner
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst || timer_reset) tmr <= 16'h0000;
    else if (tmr_load) tmr <= tmr_set;
    else if (tmr_run) tmr <= tmr + 16'h0001;
  end

  cpw_pin_model i_cpw_pin_model (.clock(clock), .src_en(src_en), .src_val(src_val),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_level(pin_level));

  cpw_unit i_cpw_unit (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
    .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data),
    .timer_count(tmr), .timer_reset(timer_reset), .adc_start(adc_start),
    .pwm_base(pwm_base), .pwm_restart(pwm_restart), .pin_in(pin_level),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .timer_clock_pin_out(tck_out),
    .timer_clock_pin_oe_n(tck_oe_n), .unit_event_flag(flag));

  // ----------------------------------------------------------------
  // bus, compare and wait helpers
  // ----------------------------------------------------------------
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : results

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic chkb(input string n, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask : chkb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_strobe <= 1'b1;
    @(posedge clock);
    wr_strobe <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clock);
    rd_strobe <= 1'b0;
    #1;
    d = rd_data;
  endtask : rd

  task automatic chkr(input string n, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(n, {8'h00, e}, {8'h00, d});
  endtask : chkr

  task automatic chkw(input string n, input logic [15:0] e);
    logic [7:0] h, l;
    rd(OFF_HIGH, h);
    rd(OFF_LOW, l);
    chk(n, e, {h, l});
  endtask : chkw

  task automatic wait_flag(input int lim);
    for (int i = 0; i < lim && flag !== 1'b1; i++) begin
      @(posedge clock);
      #1;
    end
    if (flag !== 1'b1) begin
      fail_count++;
      $display("ERROR flag wait expected 1 seen %b", flag);
      results();
    end
  endtask : wait_flag

  // pin held long enough to pass the synchroniser and capture
  task automatic set_pin(input logic v);
    @(posedge clock);
    src_val <= v;
    repeat (5) @(posedge clock);
    #1;
  endtask : set_pin

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chkr("ctrl reset", OFF_CTRL, CTRL_RESET);
    chkr("dir reset", OFF_DIR, DIR_RESET);
    chkw("word reset", WORD_RESET);
    chkr("flag reset", OFF_FLAG, 8'h00);
    chkb("oe reset", 1'b1, pin_oe_n);
    wr(OFF_CTRL, 8'hFF);
    chkr("ctrl mask", OFF_CTRL, 8'h3F);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_LOW, 8'hA5);
    wr(OFF_HIGH, 8'h3C);
    chkw("word rw", 16'h3CA5);
    wr(OFF_DIR, 8'h5A);
    wr(OFF_DATA, 8'hFF);
    chkr("dir rw", OFF_DIR, 8'h5A);
    chkr("data mask", OFF_DATA, 8'h05);
    chkb("data pin", 1'b1, pin_out);
    chkb("oe follows dir", 1'b0, pin_oe_n);
    chkb("tck out", 1'b1, tck_out);
    chkb("tck oe", 1'b0, tck_oe_n);
    wr(8'h20, 8'h77);
    chkr("unmapped", 8'h20, 8'h00);
    @(posedge clock);
    #1;
    chk("read idle", 16'h0000, {8'h00, rd_data});
    wr(OFF_DATA, 8'h00);
    wr(OFF_DIR, DIR_RESET);
    $display("test regs done");
  endtask : t_regs

  task automatic t_capture();
    logic [15:0] e;
    src_en <= 1'b1;
    wr(OFF_CTRL, {4'h0, MODE_CAP_RISE});
    wr(OFF_FLAG, 8'h00);
    @(posedge clock);
    src_val <= 1'b1;
    wait_flag(8);
    e = tmr - 16'h0001;
    chkw("capture word", e);
    @(posedge clock);
    tmr_run <= 1'b0;
    tmr_set <= 16'hA5C3;
    tmr_load <= 1'b1;
    set_pin(0);
    set_pin(1);
    // third capture lands before the second one is read
    tmr_set <= 16'h3C5A;
    set_pin(0);
    set_pin(1);
    chkw("capture overwrite", 16'h3C5A);
    chkb("flag kept", 1'b1, flag);
    tmr_set <= 16'h1234;
    set_pin(0);
    chkw("no fall capture", 16'h3C5A);
    wr(OFF_CTRL, {4'h0, MODE_CAP_FALL});
    wr(OFF_FLAG, 8'h00);
    set_pin(1);
    chkb("no rise capture", 1'b0, flag);
    set_pin(0);
    chkb("fall flag", 1'b1, flag);
    chkw("fall word", 16'h1234);
    tmr_load <= 1'b0;
    tmr_run <= 1'b1;
    $display("test capture done");
  endtask : t_capture

  task automatic t_presc();
    logic [7:0] md;
    int n;
    for (int k = 0; k < 2; k++) begin
      md = (k == 0) ? {4'h0, MODE_CAP_R4} : {4'h0, MODE_CAP_R16};
      n = (k == 0) ? 4 : 16;
      wr(OFF_CTRL, md);
      for (int i = 0; i < 2; i++) begin
        set_pin(1);
        set_pin(0);
      end
      wr(OFF_CTRL, 8'h00);
      wr(OFF_CTRL, md);
      wr(OFF_FLAG, 8'h00);
      for (int i = 1; i < n; i++) begin
        set_pin(1);
        set_pin(0);
      end
      chkb("prescale early", 1'b0, flag);
      set_pin(1);
      chkb("prescale capture", 1'b1, flag);
      set_pin(0);
    end
    $display("test prescaler done");
  endtask : t_presc

  // timer frozen while the word is loaded, so no partial word can match
  task automatic cmp_hit(input logic [3:0] md);
    logic [15:0] t;
    @(posedge clock);
    tmr_run <= 1'b0;
    @(posedge clock);
    #1;
    t = tmr + 16'h0014;
    wr(OFF_HIGH, t[15:8]);
    wr(OFF_LOW, t[7:0]);
    wr(OFF_CTRL, {4'h0, md});
    wr(OFF_FLAG, 8'h00);
    @(posedge clock);
    tmr_run <= 1'b1;
    wait_flag(60);
  endtask : cmp_hit

  task automatic t_compare();
    logic [3:0] m [4] = '{MODE_CMP_SET, MODE_CMP_SOFT, MODE_CMP_CLR, MODE_CMP_SPEC};
    logic p [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    // leave capture before the pin is driven: a driven pin loops back as edges
    wr(OFF_CTRL, 8'h00);
    wr(OFF_DIR, 8'hFB);
    src_en <= 1'b0;
    chkb("pin driven", 1'b0, pin_oe_n);
    for (int k = 0; k < 4; k++) begin
      cmp_hit(m[k]);
      chkb("compare pin", p[k], pin_out);
      chkb("timer reset", m[k] == MODE_CMP_SPEC, timer_reset);
      chkb("adc start", m[k] == MODE_CMP_SPEC, adc_start);
      @(posedge clock);
      #1;
      chkb("pulse end", 1'b0, adc_start);
      if (m[k] == MODE_CMP_SPEC) chk("timer restart", 16'h0000, tmr);
    end
    cmp_hit(MODE_CMP_SET);
    chkb("latch set", 1'b1, pin_out);
    wr(OFF_CTRL, 8'h00);
    wr(OFF_CTRL, {4'h0, MODE_CMP_SET});
    chkb("latch cleared", 1'b0, pin_out);
    $display("test compare done");
  endtask : t_compare

  task automatic t_pwm();
    logic [7:0] lo [3] = '{8'h02, 8'h02, 8'h00};
    logic [7:0] cc [3] = '{8'h0C, 8'h3C, 8'h0C};
    int ex [3] = '{8, 11, 0};
    int cnt;
    for (int k = 0; k < 3; k++) begin
      wr(OFF_CTRL, cc[k]);
      wr(OFF_LOW, lo[k]);
      cnt = 0;
      for (int i = 0; i < 21; i++) begin
        @(posedge clock);
        pwm_restart <= (i == 0);
        pwm_base <= 10'(i);
        #1;
        if (i > 0 && pin_out === 1'b1) cnt++;
      end
      chk("pwm high cycles", 16'(ex[k]), 16'(cnt));
      chkr("duty copy", OFF_HIGH, lo[k]);
    end
    wr(OFF_CTRL, 8'h00);
    chkb("pwm off low", 1'b0, pin_out);
    $display("test pwm done");
  endtask : t_pwm

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_capture();
    t_presc();
    t_compare();
    t_pwm();
    results();
  end
endmodule : cpw_unit_tb_top

`default_nettype wire
